// file: src/pfs_pkg.sv
// shared constants for the code and file state command block
package pfs_pkg;

  // ---------------------------------------------------------------------
  // command kinds presented on the command port
  // ---------------------------------------------------------------------
  localparam logic [1:0] CMD_CODE_ON    = 2'h0;
  localparam logic [1:0] CMD_UNBLOCK    = 2'h1;
  localparam logic [1:0] CMD_FILE_SUSP  = 2'h2;
  localparam logic [1:0] CMD_FILE_RESUM = 2'h3;

  // ---------------------------------------------------------------------
  // parameter and length bytes
  // ---------------------------------------------------------------------
  localparam logic [7:0] P1_ZERO        = 8'h00;
  localparam logic [7:0] P2_ZERO        = 8'h00;
  localparam logic [7:0] LC_EMPTY       = 8'h00;
  localparam logic [7:0] LC_CODE        = 8'h08;
  localparam logic [7:0] LC_UNBLOCK     = 8'h10;
  localparam logic [7:0] SEL_BY_ID      = 8'h00;
  localparam logic [7:0] SEL_PATH_ROOT  = 8'h08;
  localparam logic [7:0] SEL_PATH_CUR   = 8'h09;
  localparam logic [7:0] USAGE_NOT_USED = 8'h00;

  // ---------------------------------------------------------------------
  // counters and reset values
  // ---------------------------------------------------------------------
  localparam logic [3:0]  CODE_TRIES     = 4'h3;
  localparam logic [3:0]  UNBLK_TRIES    = 4'hA;
  localparam logic [63:0] CODE_RST_VAL   = 64'h3132333435363738;
  localparam logic [63:0] UNBLK_RST_VAL  = 64'h3837363534333231;
  localparam logic [7:0]  USAGE_RST_VAL  = 8'h08;
  localparam int          NUM_FILES      = 8;
  localparam logic [2:0]  FILE_RST_CUR   = 3'h0;
  localparam logic [NUM_FILES-1:0] SUSP_ACC_RST = 8'hFF;
  localparam logic [NUM_FILES-1:0] RESUM_ACC_RST = 8'hFF;

  // ---------------------------------------------------------------------
  // status words
  // ---------------------------------------------------------------------
  localparam logic [15:0] SW_OK          = 16'h9000;
  localparam logic [15:0] SW_TRIES_BASE  = 16'h63C0;
  localparam logic [15:0] SW_BLOCKED     = 16'h6983;
  localparam logic [15:0] SW_BAD_STATE   = 16'h6985;
  localparam logic [15:0] SW_NO_ACCESS   = 16'h6982;
  localparam logic [15:0] SW_BAD_P1P2    = 16'h6B00;
  localparam logic [15:0] SW_BAD_LEN     = 16'h6700;
  localparam logic [15:0] SW_NOT_FOUND   = 16'h6A82;
  localparam logic [15:0] SW_FILE_SUSP   = 16'h6283;

  // ---------------------------------------------------------------------
  // register port map
  // ---------------------------------------------------------------------
  localparam logic [3:0] REG_CODE_STATE = 4'h0;
  localparam logic [3:0] REG_FILE_STATE = 4'h1;
  localparam logic [3:0] REG_ACCESS     = 4'h2;
  localparam logic [3:0] REG_USAGE      = 4'h3;
  localparam logic [3:0] REG_CUR_FILE   = 4'h4;
  localparam logic [3:0] REG_LAST_SW    = 4'h5;
  localparam logic [3:0] REG_OPT_BLOCK  = 4'h6;
  localparam int         CS_CODE_CNT    = 0;
  localparam int         CS_UNBLK_CNT   = 4;
  localparam int         CS_ENABLED     = 8;
  localparam int         CS_BLOCKED     = 9;
  localparam int         CS_UNBLK_BLK   = 10;
  localparam int         CS_GRANTED     = 11;
  localparam int         CS_LEVEL_OK    = 12;

endpackage

// file: src/pfs_core.sv
// command logic for code enable, unblock and leaf file suspend/resume
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
module pfs_core
  import pfs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        cmd_valid,
  input  wire logic [1:0]  cmd_kind,
  input  wire logic [7:0]  cmd_p1,
  input  wire logic [7:0]  cmd_p2,
  input  wire logic [7:0]  cmd_lc,
  input  wire logic [63:0] cmd_data_a,
  input  wire logic [63:0] cmd_data_b,
  input  wire logic [2:0]  cmd_file_idx,
  input  wire logic        op_valid,
  input  wire logic        op_is_select,
  input  wire logic [2:0]  op_file_idx,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             rsp_valid,
  output logic [15:0]      rsp_status_word,
  output logic             op_reject,
  output logic             code_access_granted,
  output logic [7:0]       key_usage_object,
  output logic [2:0]       cur_leaf_file,
  output logic [NUM_FILES-1:0] lifecycle_state_object
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  logic [63:0]          code_val_ff;
  logic [63:0]          unblk_val_ff;
  logic [3:0]           code_cnt_ff;
  logic [3:0]           unblk_cnt_ff;
  logic                 enabled_ff;
  logic                 blocked_ff;
  logic                 unblk_blk_ff;
  logic                 level_ok_ff;
  logic                 opt_en_on_block_ff;
  logic [7:0]           usage_ff;
  logic [NUM_FILES-1:0] susp_ff;
  logic [NUM_FILES-1:0] susp_acc_ff;
  logic [NUM_FILES-1:0] resum_acc_ff;
  logic [2:0]           cur_ff;
  logic                 rsp_valid_ff;
  logic [15:0]          sw_ff;
  logic                 op_reject_ff;
  logic                 granted_ff;
  logic [31:0]          rdata_ff;

  // ---------------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------------
  logic        is_on;
  logic        is_unblk;
  logic        is_file;
  logic        code_ok;
  logic        unblk_ok;
  logic        file_cur;
  logic        sel_ok;
  logic [2:0]  tgt;
  logic        file_go;
  logic [15:0] file_sw;
  logic [3:0]  unblk_dec;

  assign is_on    = cmd_valid && (cmd_kind == CMD_CODE_ON);
  assign is_unblk = cmd_valid && (cmd_kind == CMD_UNBLOCK);
  assign is_file  = cmd_valid && (cmd_kind[1] == 1'b1);
  assign code_ok  = (cmd_data_a == code_val_ff);
  assign unblk_ok = (cmd_data_a == unblk_val_ff);
  assign unblk_dec = unblk_cnt_ff - 4'h1;
  // empty data with zero parameters means the current file
  assign file_cur = (cmd_p1 == P1_ZERO) && (cmd_p2 == P2_ZERO)
                    && (cmd_lc == LC_EMPTY);
  assign sel_ok   = (cmd_p2 == P2_ZERO) &&
                    ((cmd_p1 == SEL_BY_ID) || (cmd_p1 == SEL_PATH_ROOT) ||
                     (cmd_p1 == SEL_PATH_CUR));
  assign tgt      = file_cur ? cur_ff : cmd_file_idx;

  // file command outcome, suspend and resume share one path
  always_comb begin
    file_go = 1'b0;
    file_sw = SW_OK;
    if (!file_cur && !sel_ok) begin
      file_sw = SW_BAD_P1P2;
    end else if (!file_cur && cmd_lc == LC_EMPTY) begin
      file_sw = SW_BAD_LEN;
    end else if (cmd_kind == CMD_FILE_SUSP) begin
      if (!susp_acc_ff[tgt]) begin
        file_sw = SW_NO_ACCESS;
      end else if (susp_ff[tgt]) begin
        file_sw = SW_BAD_STATE;
      end else begin
        file_go = 1'b1;
      end
    end else begin
      if (!resum_acc_ff[tgt]) begin
        file_sw = SW_NO_ACCESS;
      end else if (!susp_ff[tgt]) begin
        file_sw = SW_BAD_STATE;
      end else begin
        file_go = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // code enable and counters
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      code_cnt_ff <= CODE_TRIES;
      enabled_ff  <= 1'b0;
      blocked_ff  <= 1'b0;
      code_val_ff <= CODE_RST_VAL;
      level_ok_ff <= 1'b0;
    end else if (is_on && cmd_p1 == P1_ZERO && cmd_lc == LC_CODE
                 && !enabled_ff && !blocked_ff) begin
      if (code_ok) begin
        code_cnt_ff <= CODE_TRIES;
        enabled_ff  <= 1'b1;
      end else begin
        code_cnt_ff <= code_cnt_ff - 4'h1;
        if (code_cnt_ff == 4'h1) begin
          blocked_ff <= 1'b1;
          enabled_ff <= opt_en_on_block_ff;
        end
      end
    end else if (is_unblk && cmd_p1 == P1_ZERO && cmd_lc == LC_UNBLOCK
                 && !unblk_blk_ff && unblk_ok) begin
      code_val_ff <= cmd_data_b;
      code_cnt_ff <= CODE_TRIES;
      enabled_ff  <= 1'b1;
      blocked_ff  <= 1'b0;
      level_ok_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // unblock counter; a wrong value touches nothing else
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      unblk_cnt_ff <= UNBLK_TRIES;
      unblk_blk_ff <= 1'b0;
      unblk_val_ff <= UNBLK_RST_VAL;
    end else if (is_unblk && cmd_p1 == P1_ZERO && cmd_lc == LC_UNBLOCK
                 && !unblk_blk_ff) begin
      if (unblk_ok) begin
        unblk_cnt_ff <= UNBLK_TRIES;
      end else begin
        unblk_cnt_ff <= unblk_dec;
        if (unblk_cnt_ff == 4'h1) begin
          unblk_blk_ff <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // alternative key usage qualifier
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      usage_ff <= USAGE_RST_VAL;
    end else if (is_on && cmd_p1 == P1_ZERO && cmd_lc == LC_CODE
                 && !enabled_ff && !blocked_ff && code_ok) begin
      usage_ff <= USAGE_NOT_USED;
    end else if (reg_wr && reg_addr == REG_USAGE) begin
      usage_ff <= reg_wdata[7:0];
    end
  end

  // ---------------------------------------------------------------------
  // lifecycle flags and current file
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      susp_ff <= '0;
      cur_ff  <= FILE_RST_CUR;
    end else if (is_file && file_go) begin
      susp_ff[tgt] <= (cmd_kind == CMD_FILE_SUSP);
      cur_ff       <= tgt;
    end
    // failed file commands leave cur_ff untouched
  end

  // access conditions and optional block behaviour, set by software
  always_ff @(posedge clk) begin
    if (srst) begin
      susp_acc_ff        <= SUSP_ACC_RST;
      resum_acc_ff       <= RESUM_ACC_RST;
      opt_en_on_block_ff <= 1'b0;
    end else if (reg_wr && reg_addr == REG_ACCESS) begin
      susp_acc_ff  <= reg_wdata[NUM_FILES-1:0];
      resum_acc_ff <= reg_wdata[2*NUM_FILES-1:NUM_FILES];
    end else if (reg_wr && reg_addr == REG_OPT_BLOCK) begin
      opt_en_on_block_ff <= reg_wdata[0];
    end
  end

  // ---------------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_valid_ff <= 1'b0;
      sw_ff        <= SW_OK;
    end else begin
      rsp_valid_ff <= cmd_valid;
      if (is_on) begin
        if (cmd_p1 != P1_ZERO) begin
          sw_ff <= SW_BAD_P1P2;
        end else if (cmd_lc != LC_CODE) begin
          sw_ff <= SW_BAD_LEN;
        end else if (blocked_ff) begin
          sw_ff <= SW_BLOCKED;
        end else if (enabled_ff) begin
          sw_ff <= SW_BAD_STATE;
        end else if (code_ok) begin
          sw_ff <= SW_OK;
        end else begin
          sw_ff <= SW_TRIES_BASE | {12'h000, code_cnt_ff - 4'h1};
        end
      end else if (is_unblk) begin
        if (cmd_p1 != P1_ZERO) begin
          sw_ff <= SW_BAD_P1P2;
        end else if (cmd_lc == LC_EMPTY) begin
          sw_ff <= SW_TRIES_BASE | {12'h000, unblk_cnt_ff};
        end else if (cmd_lc != LC_UNBLOCK) begin
          sw_ff <= SW_BAD_LEN;
        end else if (unblk_blk_ff) begin
          sw_ff <= SW_BLOCKED;
        end else if (unblk_ok) begin
          sw_ff <= SW_OK;
        end else begin
          sw_ff <= SW_TRIES_BASE | {12'h000, unblk_dec};
        end
      end else if (is_file) begin
        sw_ff <= file_sw;
      end
    end
  end

  // operations other than select or resume on a suspended file
  always_ff @(posedge clk) begin
    if (srst) begin
      op_reject_ff <= 1'b0;
    end else begin
      op_reject_ff <= op_valid && !op_is_select
                      && susp_ff[op_file_idx];
    end
  end

  // blocked and disabled keeps access; enabled needs a verified level
  always_ff @(posedge clk) begin
    if (srst) begin
      granted_ff <= 1'b1;
    end else begin
      granted_ff <= !enabled_ff || (!blocked_ff && level_ok_ff);
    end
  end

  // ---------------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (reg_addr == REG_CODE_STATE) begin
        rdata_ff <= {19'h00000, level_ok_ff, granted_ff, unblk_blk_ff,
                     blocked_ff, enabled_ff, unblk_cnt_ff, code_cnt_ff};
      end else if (reg_addr == REG_FILE_STATE) begin
        rdata_ff <= {24'h000000, susp_ff};
      end else if (reg_addr == REG_ACCESS) begin
        rdata_ff <= {16'h0000, resum_acc_ff, susp_acc_ff};
      end else if (reg_addr == REG_USAGE) begin
        rdata_ff <= {24'h000000, usage_ff};
      end else if (reg_addr == REG_CUR_FILE) begin
        rdata_ff <= {29'h00000000, cur_ff};
      end else if (reg_addr == REG_LAST_SW) begin
        rdata_ff <= {16'h0000, sw_ff};
      end else if (reg_addr == REG_OPT_BLOCK) begin
        rdata_ff <= {31'h00000000, opt_en_on_block_ff};
      end else begin
        rdata_ff <= 32'h0000_0000;
      end
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  assign reg_rdata              = rdata_ff;
  assign rsp_valid              = rsp_valid_ff;
  assign rsp_status_word        = sw_ff;
  assign op_reject              = op_reject_ff;
  assign code_access_granted    = granted_ff;
  assign key_usage_object       = usage_ff;
  assign cur_leaf_file          = cur_ff;
  assign lifecycle_state_object = susp_ff;

endmodule

// file: bench/pfs_chk.sv
// port-level assertion checker for pfs_core
`timescale 1ns/100ps
module pfs_chk
  import pfs_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 srst,
  input wire logic                 cmd_valid,
  input wire logic [1:0]           cmd_kind,
  input wire logic [7:0]           cmd_lc,
  input wire logic [2:0]           cmd_file_idx,
  input wire logic                 op_valid,
  input wire logic                 op_is_select,
  input wire logic [2:0]           op_file_idx,
  input wire logic                 rsp_valid,
  input wire logic [15:0]          rsp_status_word,
  input wire logic                 op_reject,
  input wire logic                 code_access_granted,
  input wire logic [7:0]           key_usage_object,
  input wire logic [2:0]           cur_leaf_file,
  input wire logic [NUM_FILES-1:0] lifecycle_state_object
);
  // ---------------------------------------------------------------
  // command tracking
  // ---------------------------------------------------------------
  logic [1:0] kind_ff;
  logic [2:0] tgt_ff;
  logic       lcu_ff;
  logic       ub_ff;

  // empty data field means the current leaf file is the target
  always_ff @(posedge clk) begin
    if (cmd_valid) begin
      kind_ff <= cmd_kind;
      lcu_ff  <= cmd_lc == LC_UNBLOCK;
      tgt_ff  <= (cmd_lc == LC_EMPTY) ? cur_leaf_file : cmd_file_idx;
    end
  end

  // sticky: nothing but reset clears a blocked unblock code
  always_ff @(posedge clk) begin
    if (srst) begin
      ub_ff <= 1'b0;
    end else if (rsp_valid && kind_ff == CMD_UNBLOCK && lcu_ff &&
                 rsp_status_word == SW_TRIES_BASE) begin
      ub_ff <= 1'b1;
    end
  end

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_usage_off;
    rsp_valid && kind_ff == CMD_CODE_ON && rsp_status_word == SW_OK
      |-> key_usage_object == USAGE_NOT_USED;
  endproperty
  a_usage_off: assert property (p_usage_off)
    else $error("usage qualifier not cleared on enable");

  property p_ub_blocked;
    ub_ff && cmd_valid && cmd_kind == CMD_UNBLOCK && cmd_lc == LC_UNBLOCK
      |=> rsp_status_word == SW_BLOCKED;
  endproperty
  a_ub_blocked: assert property (p_ub_blocked)
    else $error("blocked unblock code not answered 6983");

  property p_query;
    cmd_valid && cmd_kind == CMD_UNBLOCK && cmd_lc == LC_EMPTY && !ub_ff
      |=> rsp_status_word[15:4] == SW_TRIES_BASE[15:4] &&
          $stable(code_access_granted) && $stable(cur_leaf_file);
  endproperty
  a_query: assert property (p_query)
    else $error("retry query wrong word or changed state");

  property p_err_hold;
    rsp_valid && rsp_status_word != SW_OK &&
      rsp_status_word[15:4] != SW_TRIES_BASE[15:4]
      |-> $stable(lifecycle_state_object) && $stable(cur_leaf_file) &&
          $stable(code_access_granted);
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("refused command changed state");

  property p_cur_ok;
    rsp_valid && kind_ff[1] && rsp_status_word == SW_OK
      |-> cur_leaf_file == tgt_ff;
  endproperty
  a_cur_ok: assert property (p_cur_ok)
    else $error("current leaf file not the target");

  property p_susp;
    rsp_valid && kind_ff == CMD_FILE_SUSP && rsp_status_word == SW_OK
      |-> lifecycle_state_object[tgt_ff];
  endproperty
  a_susp: assert property (p_susp)
    else $error("suspend did not mark the file");

  property p_resum;
    rsp_valid && kind_ff == CMD_FILE_RESUM && rsp_status_word == SW_OK
      |-> !lifecycle_state_object[tgt_ff];
  endproperty
  a_resum: assert property (p_resum)
    else $error("resume did not clear the file");

  property p_op_rej;
    op_valid && !op_is_select && lifecycle_state_object[op_file_idx]
      |=> op_reject;
  endproperty
  a_op_rej: assert property (p_op_rej)
    else $error("operation on suspended file not refused");
endmodule

bind pfs_core pfs_chk chk_u (.*);

// file: bench/pfs_term.sv
// terminal model driving the command port
`timescale 1ns/100ps
module pfs_term
  import pfs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_status_word,
  output logic             cmd_valid,
  output logic [1:0]       cmd_kind,
  output logic [7:0]       cmd_p1,
  output logic [7:0]       cmd_p2,
  output logic [7:0]       cmd_lc,
  output logic [63:0]      cmd_data_a,
  output logic [63:0]      cmd_data_b,
  output logic [2:0]       cmd_file_idx
);
  // ---------------------------------------------------------------
  // command issue
  // ---------------------------------------------------------------
  initial begin
    {cmd_valid, cmd_kind, cmd_p1, cmd_p2, cmd_lc} = '0;
    {cmd_data_a, cmd_data_b, cmd_file_idx} = '0;
  end

  task automatic send(input logic [1:0] k, input logic [7:0] p1, lc,
                      input logic [63:0] a, b, input logic [2:0] f,
                      input logic [1:0] g, output logic [16:0] r);
    repeat (g) @(posedge clk);
    @(posedge clk);
    cmd_valid    <= 1'b1;
    cmd_kind     <= k;
    cmd_p1       <= p1;
    cmd_p2       <= P2_ZERO;
    cmd_lc       <= lc;
    cmd_data_a   <= a;
    cmd_data_b   <= b;
    cmd_file_idx <= f;
    @(posedge clk);
    cmd_valid  <= 1'b0;
    // released data shows garbage so a stale value cannot pass
    cmd_data_a <= ~a;
    cmd_data_b <= ~b;
    // sample mid-cycle while the registered answer stands
    @(negedge clk);
    r = {rsp_valid, rsp_status_word};
  endtask
endmodule

// file: bench/tb.sv
// self-checking testbench for pfs_core
`timescale 1ns/100ps
module tb;
  import pfs_pkg::*;
  logic        clk, srst, cmd_valid, op_valid, op_is_select, reg_wr, reg_rd;
  logic        rsp_valid, op_reject, code_access_granted;
  logic [1:0]  cmd_kind;
  logic [2:0]  cmd_file_idx, op_file_idx, cur_leaf_file, f;
  logic [3:0]  reg_addr;
  logic [7:0]  cmd_p1, cmd_p2, cmd_lc, key_usage_object;
  logic [7:0]  lifecycle_state_object;
  logic [15:0] rsp_status_word;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [63:0] cmd_data_a, cmd_data_b, nc;
  logic [16:0] r;
  logic [7:0]  sel [3] = '{SEL_BY_ID, SEL_PATH_ROOT, SEL_PATH_CUR};
  int          n_errors, n_tests, seed, i, k;

  pfs_core dut_u (.*);
  pfs_term term_u (.*);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic rst;
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
  endtask

  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_wdata <= ~d;
    @(negedge clk);
    q = reg_rdata;
    if (w) chk("rdata_idle", q, 32'h0);
  endtask

  task automatic op(input logic [2:0] fi, input logic s, e);
    @(posedge clk);
    op_valid     <= 1'b1;
    op_is_select <= s;
    op_file_idx  <= fi;
    @(posedge clk);
    op_valid <= 1'b0;
    @(negedge clk);
    chk("op_reject", op_reject, e);
  endtask

  task automatic cmd(input logic [1:0] ck, input logic [7:0] p1, lc,
                     input logic [63:0] a, b, input logic [2:0] fi,
                     input logic [15:0] e);
    term_u.send(ck, p1, lc, a, b, fi, 2'($random(seed)), r);
    chk("status_word", 32'(r), {15'h0, 1'b1, e});
  endtask

  function automatic logic [15:0] tries(input logic [3:0] n);
    return SW_TRIES_BASE | {12'h0, n};
  endfunction

  function automatic logic [11:0] cs(input logic [3:0] cc, uc,
                                     input logic en, bl, ub, gr);
    return {gr, ub, bl, en, uc, cc};
  endfunction

  // a value that differs from the stored one in at least bit 0
  function automatic logic [63:0] bad(input logic [63:0] v);
    return v ^ {32'($random(seed)), 32'($random(seed)) | 32'h1};
  endfunction

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    seed = 96;
    n_errors = 0;
    n_tests = 0;
    srst = 1'b1;
    {op_valid, op_is_select, op_file_idx, reg_wr, reg_rd} = '0;
    {reg_addr, reg_wdata} = '0;
    rst();
    acc(0, REG_CODE_STATE, 0, rd);
    chk("code_state", rd[11:0], cs(3, 4'hA, 0, 0, 0, 1));
    acc(0, REG_USAGE, 0, rd);
    chk("usage", rd, 32'h8);
    acc(1, 4'hF, 32'hFFFF_FFFF, rd);
    acc(0, 4'hF, 0, rd);
    chk("unmapped", rd, 32'h0);
    cmd(CMD_CODE_ON, P1_ZERO, LC_CODE, bad(CODE_RST_VAL), 0, 0, tries(2));
    cmd(CMD_CODE_ON, P1_ZERO, LC_CODE, CODE_RST_VAL, 0, 0, SW_OK);
    chk("usage", key_usage_object, USAGE_NOT_USED);
    acc(0, REG_CODE_STATE, 0, rd);
    chk("code_state", rd[11:0], cs(3, 4'hA, 1, 0, 0, 0));
    for (k = 0; k < 2; k++) begin
      rst();
      acc(1, REG_OPT_BLOCK, k, rd);
      for (i = 2; i >= 0; i--) begin
        cmd(CMD_CODE_ON, P1_ZERO, LC_CODE, bad(CODE_RST_VAL), 0, 0, tries(i));
      end
      acc(0, REG_CODE_STATE, 0, rd);
      chk("code_state", rd[11:0], cs(0, 4'hA, k, 1, 0, !k));
      cmd(CMD_CODE_ON, P1_ZERO, LC_CODE, CODE_RST_VAL, 0, 0, SW_BLOCKED);
      cmd(CMD_UNBLOCK, P1_ZERO, LC_EMPTY, 0, 0, 0, tries(4'hA));
      nc = {$random(seed), $random(seed)};
      cmd(CMD_UNBLOCK, P1_ZERO, LC_UNBLOCK, bad(UNBLK_RST_VAL), nc, 0, tries(9));
      acc(0, REG_CODE_STATE, 0, rd);
      chk("code_state", rd[11:0], cs(0, 9, k, 1, 0, !k));
      cmd(CMD_UNBLOCK, P1_ZERO, LC_UNBLOCK, UNBLK_RST_VAL, nc, 0, SW_OK);
      acc(0, REG_CODE_STATE, 0, rd);
      chk("code_state", rd[12:0], {1'b1, cs(3, 4'hA, 1, 0, 0, 1)});
      cmd(CMD_CODE_ON, P1_ZERO, LC_CODE, nc, 0, 0, SW_BAD_STATE);
    end
    rst();
    for (i = 9; i >= 0; i--) begin
      cmd(CMD_UNBLOCK, P1_ZERO, LC_UNBLOCK, bad(UNBLK_RST_VAL), nc, 0, tries(i));
    end
    cmd(CMD_UNBLOCK, P1_ZERO, LC_UNBLOCK, UNBLK_RST_VAL, nc, 0, SW_BLOCKED);
    acc(0, REG_CODE_STATE, 0, rd);
    chk("code_state", rd[11:0], cs(3, 0, 0, 0, 1, 1));
    for (i = 0; i < 3; i++) begin
      f = 3'(i * 3 + ($random(seed) & 1));
      cmd(CMD_FILE_SUSP, sel[i], 8'h02, 0, 0, f, SW_OK);
      chk("cur_file", cur_leaf_file, f);
      chk("suspended", lifecycle_state_object[f], 1'b1);
      op(f, 0, 1);
      op(f, 1, 0);
      cmd(CMD_FILE_SUSP, sel[i], 8'h02, 0, 0, f, SW_BAD_STATE);
      cmd(CMD_FILE_RESUM, P1_ZERO, LC_EMPTY, 0, 0, ~f, SW_OK);
      chk("suspended", lifecycle_state_object, 8'h0);
      chk("cur_file", cur_leaf_file, f);
    end
    acc(1, REG_ACCESS, 32'hDFDF, rd);
    cmd(CMD_FILE_SUSP, SEL_BY_ID, 8'h02, 0, 0, 3'h5, SW_NO_ACCESS);
    chk("suspended", lifecycle_state_object, 8'h0);
    acc(1, REG_ACCESS, 32'hDFFF, rd);
    cmd(CMD_FILE_SUSP, SEL_BY_ID, 8'h02, 0, 0, 3'h5, SW_OK);
    cmd(CMD_FILE_RESUM, SEL_BY_ID, 8'h02, 0, 0, 3'h5, SW_NO_ACCESS);
    chk("suspended", lifecycle_state_object, 8'h20);
    cmd(CMD_FILE_RESUM, 8'h01, 8'h02, 0, 0, 3'h5, SW_BAD_P1P2);
    acc(0, REG_LAST_SW, 0, rd);
    chk("last_sw", rd, {16'h0000, SW_BAD_P1P2});
    acc(0, REG_CUR_FILE, 0, rd);
    chk("cur_file_reg", rd, 32'h5);
    wrap_up();
  end

  // whole run is a few hundred cycles; far beyond that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule
